// >>> rtl/msg_crc.sv
`timescale 1ns/1ps
`default_nettype none
module msg_crc
  import sensor_port_pkg::*;
#(
  parameter logic [7:0] POLY = CRC_POLY
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       update_i,
  input  wire logic [7:0] byte_i,
  output var  logic [7:0] crc_o
);

  logic [7:0] crc_q;
  logic [7:0] crc_d;

  // Byte-wise, low bit first, shared by request check and reply trailer
  always_comb
  begin
    logic [7:0] c;
    c = (clear_i ? CRC_INIT : crc_q) ^ byte_i;
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c ^ POLY) >> 1) : (c >> 1);
    end
    if (update_i)
      crc_d = c;
    else if (clear_i)
      crc_d = CRC_INIT;
    else
      crc_d = crc_q;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      crc_q <= CRC_INIT;
    else
      crc_q <= crc_d;
  end

  assign crc_o = crc_q;

endmodule // msg_crc
`default_nettype wire

// >>> rtl/sensor_port_pkg.sv
package sensor_port_pkg;

  localparam logic [6:0] I2C_DEV_ADDR = 7'h32;
  localparam int         WR_BIT       = 7;
  localparam logic [7:0] CRC_POLY     = 8'h91;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;

  localparam logic [7:0] ADDR_ID       = 8'h00;
  localparam logic [7:0] ADDR_HW_REV   = 8'h01;
  localparam logic [7:0] ADDR_FW_MAJ   = 8'h02;
  localparam logic [7:0] ADDR_FW_MIN   = 8'h03;
  localparam logic [7:0] ADDR_RATE     = 8'h04;
  localparam logic [7:0] ADDR_ACC_FS   = 8'h05;
  localparam logic [7:0] ADDR_GYR_FS_L = 8'h06;
  localparam logic [7:0] ADDR_GYR_FS_H = 8'h07;
  localparam logic [7:0] ADDR_OP       = 8'h08;
  localparam logic [7:0] ADDR_CAL      = 8'h09;
  localparam logic [7:0] ADDR_SELFTEST = 8'h0A;
  localparam logic [7:0] ADDR_FLAGS_L  = 8'h0B;
  localparam logic [7:0] ADDR_FLAGS_H  = 8'h0C;
  localparam logic [7:0] ADDR_TS_0     = 8'h10;
  localparam logic [7:0] ADDR_TS_1     = 8'h11;
  localparam logic [7:0] ADDR_TS_2     = 8'h12;
  localparam logic [7:0] ADDR_TS_3     = 8'h13;
  localparam logic [7:0] LAST_REG_ADDR = 8'h13;

  localparam logic [7:0] RATE_RESET = 8'h3C;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [3:0] I2C_ACK    = 4'h8;
  localparam logic [3:0] I2C_B7     = 4'h7;
  localparam logic [1:0] SPI_RX_CRC = 2'h2;
  localparam logic [1:0] SPI_RX_END = 2'h3;

  localparam int CLK_HZ       = 50_000_000;
  localparam int TS_TICK_US   = 1000;
  localparam int TS_TICK_CYC  = CLK_HZ / 1_000_000 * TS_TICK_US;

  typedef struct packed {
    logic [7:0]  hw_rev;
    logic [7:0]  fw_major;
    logic [7:0]  fw_minor;
    logic [7:0]  accel_fs;
    logic [15:0] rate_fs;
    logic [7:0]  op_state;
    logic [7:0]  cal_state;
    logic [7:0]  selftest;
    logic [15:0] flags;
  } sensor_info_t;

  typedef enum logic [4:0] {
    I_IDLE  = 5'h01,
    I_ADDR  = 5'h02,
    I_REG   = 5'h04,
    I_WDATA = 5'h08,
    I_RDATA = 5'h10
  } i2c_state_t;

  typedef struct packed {
    i2c_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic       drive_low;
  } i2c_t;

  localparam i2c_t I2C_RST = '{state: I_IDLE, default: '0};

  typedef struct packed {
    logic       data_phase;
    logic [2:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [1:0] rx_bytes;
    logic [7:0] addr;
    logic [7:0] arg;
    logic       crc_ok;
    logic       pend_rd;
    logic [7:0] rd_addr;
    logic [7:0] rd_cnt;
    logic [7:0] tx_idx;
    logic       miso;
  } spi_t;

  localparam spi_t SPI_RST = '0;

endpackage

// >>> rtl/sensor_register_access_port.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_register_access_port
  import sensor_port_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID  = 8'hA5, // Arbitrary identity value
  parameter logic [7:0] RATE_INIT  = RATE_RESET,
  parameter int         TICK_CYC   = TS_TICK_CYC
)
(
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         spi_sclk_i,
  input  wire logic         spi_cs_n_i,
  input  wire logic         spi_mosi_i,
  output var  logic         spi_miso_o,
  output var  logic         spi_miso_oe_o,
  input  wire logic         i2c_scl_i,
  input  wire logic         i2c_sda_i,
  output var  logic         i2c_sda_o,
  output var  logic         i2c_sda_oe_o,
  input  wire sensor_info_t info_i,
  input  wire logic         sample_ready_i,
  output var  logic [7:0]   sample_rate_hz_o,
  output var  logic [31:0]  timestamp_o
);

  // Pin synchronisers; stage 0 feeds stage 1 only
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] mosi_s;
  logic [2:0] scl_s;
  logic [2:0] sda_s;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sclk_s <= 3'h7;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
      scl_s  <= 3'h7;
      sda_s  <= 3'h7;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], spi_sclk_i};
      cs_s   <= {cs_s[1:0], spi_cs_n_i};
      mosi_s <= {mosi_s[0], spi_mosi_i};
      scl_s  <= {scl_s[1:0], i2c_scl_i};
      sda_s  <= {sda_s[1:0], i2c_sda_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;

  // Mode 3: shift in on rising, shift out on falling
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_fall   = ~cs_s[1] & cs_s[2];
  assign cs_rise   = cs_s[1] & ~cs_s[2];
  assign cs_low    = ~cs_s[1];
  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign i2c_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign i2c_stop  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // Stored state: rate register and sample timestamp
  logic [7:0]  rate_q;
  logic [7:0]  rate_d;
  logic [31:0] ts_q;
  logic [31:0] ts_d;
  logic [31:0] ms_q;
  logic [31:0] ms_d;
  logic [31:0] tick_q;
  logic [31:0] tick_d;

  // Register view; multi-byte values low byte first
  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    case (a)
      ADDR_ID:       reg_rd = DEVICE_ID;
      ADDR_HW_REV:   reg_rd = info_i.hw_rev;
      ADDR_FW_MAJ:   reg_rd = info_i.fw_major;
      ADDR_FW_MIN:   reg_rd = info_i.fw_minor;
      ADDR_RATE:     reg_rd = rate_q;
      ADDR_ACC_FS:   reg_rd = info_i.accel_fs;
      ADDR_GYR_FS_L: reg_rd = info_i.rate_fs[7:0];
      ADDR_GYR_FS_H: reg_rd = info_i.rate_fs[15:8];
      ADDR_OP:       reg_rd = info_i.op_state;
      ADDR_CAL:      reg_rd = info_i.cal_state;
      ADDR_SELFTEST: reg_rd = info_i.selftest;
      ADDR_FLAGS_L:  reg_rd = info_i.flags[7:0];
      ADDR_FLAGS_H:  reg_rd = info_i.flags[15:8];
      ADDR_TS_0:     reg_rd = ts_q[7:0];
      ADDR_TS_1:     reg_rd = ts_q[15:8];
      ADDR_TS_2:     reg_rd = ts_q[23:16];
      ADDR_TS_3:     reg_rd = ts_q[31:24];
      default:       reg_rd = 8'h00;
    endcase
  endfunction

  // SPI request and data phases
  spi_t       spi_q;
  spi_t       spi_d;
  logic       crc_clr;
  logic       crc_upd;
  logic [7:0] crc_byte;
  logic [7:0] crc_val;
  logic       spi_wr;
  logic [7:0] spi_byte;
  logic [7:0] cnt_room;

  assign spi_byte = {spi_q.rx[6:0], mosi_s[1]};
  assign cnt_room = LAST_REG_ADDR - spi_q.addr;

  always_comb
  begin
    spi_d    = spi_q;
    crc_clr  = 1'b0;
    crc_upd  = 1'b0;
    crc_byte = spi_byte;
    spi_wr   = 1'b0;
    if (cs_fall)
    begin
      spi_d.bitcnt     = '0;
      spi_d.rx_bytes   = '0;
      spi_d.crc_ok     = 1'b0;
      spi_d.data_phase = spi_q.pend_rd;
      crc_clr          = 1'b1;
      if (spi_q.pend_rd)
      begin
        spi_d.tx     = reg_rd(spi_q.rd_addr);
        crc_byte     = spi_d.tx;
        crc_upd      = 1'b1;
        spi_d.tx_idx = 8'h01;
      end
    end
    else if (cs_rise)
    begin
      spi_d.data_phase = 1'b0;
      if (spi_q.data_phase)
        spi_d.pend_rd = 1'b0;
      else if (spi_q.crc_ok)
      begin
        if (spi_q.addr[WR_BIT])
          spi_wr = (spi_q.addr[6:0] == ADDR_RATE[6:0]);
        else if (spi_q.arg != 8'h00 && spi_q.addr <= LAST_REG_ADDR && spi_q.arg <= cnt_room)
        begin
          spi_d.pend_rd = 1'b1;
          spi_d.rd_addr = spi_q.addr;
          spi_d.rd_cnt  = spi_q.arg;
        end
      end
    end
    else if (cs_low)
    begin
      if (sclk_rise)
      begin
        spi_d.rx     = spi_byte;
        spi_d.bitcnt = spi_q.bitcnt + 3'h1;
        if (spi_q.bitcnt == BIT_LAST && !spi_q.data_phase)
        begin
          if (spi_q.rx_bytes != SPI_RX_END)
            spi_d.rx_bytes = spi_q.rx_bytes + 2'h1;
          case (spi_q.rx_bytes)
            2'h0:
            begin
              spi_d.addr = spi_byte;
              crc_upd    = 1'b1;
            end
            2'h1:
            begin
              spi_d.arg = spi_byte;
              crc_upd   = 1'b1;
            end
            SPI_RX_CRC: spi_d.crc_ok = (spi_byte == crc_val);
            default: spi_d.crc_ok = spi_q.crc_ok;
          endcase
        end
        else if (spi_q.bitcnt == BIT_LAST)
        begin
          spi_d.tx_idx = spi_q.tx_idx + 8'h01;
          if (spi_q.tx_idx < spi_q.rd_cnt)
          begin
            spi_d.tx = reg_rd(spi_q.rd_addr + spi_q.tx_idx);
            crc_byte = spi_d.tx;
            crc_upd  = 1'b1;
          end
          else if (spi_q.tx_idx == spi_q.rd_cnt)
            spi_d.tx = crc_val;
          else
            spi_d.tx = 8'h00;
        end
      end
      if (sclk_fall)
      begin
        spi_d.miso = spi_q.tx[7];
        spi_d.tx   = {spi_q.tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      spi_q <= SPI_RST;
    else
      spi_q <= spi_d;
  end

  msg_crc u_crc (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .clear_i   (crc_clr),
    .update_i  (crc_upd),
    .byte_i    (crc_byte),
    .crc_o     (crc_val)
  );

  assign spi_miso_o    = spi_q.miso;
  assign spi_miso_oe_o = cs_low & spi_q.data_phase;

  // I2C slave; data out changes while clock is low
  i2c_t       i2c_q;
  i2c_t       i2c_d;
  logic       i2c_wr;
  logic [7:0] i2c_byte;
  logic [7:0] ptr_inc;

  assign i2c_byte = i2c_q.rx;
  assign ptr_inc  = i2c_q.ptr + 8'h01;

  always_comb
  begin
    i2c_d  = i2c_q;
    i2c_wr = 1'b0;
    if (i2c_start)
    begin
      i2c_d.state     = I_ADDR;
      i2c_d.bitcnt    = I2C_ACK; // Start's own clock fall rolls this to 0
      i2c_d.drive_low = 1'b0;
    end
    else if (i2c_stop)
    begin
      i2c_d.state     = I_IDLE;
      i2c_d.drive_low = 1'b0;
    end
    else if (i2c_q.state != I_IDLE)
    begin
      if (scl_rise)
      begin
        if (i2c_q.bitcnt < I2C_ACK)
          i2c_d.rx = {i2c_q.rx[6:0], sda_s[1]};
        else if (i2c_q.state == I_RDATA && !i2c_q.drive_low)
        begin
          if (sda_s[1])
            i2c_d.state = I_IDLE;
          else if (i2c_q.ptr < LAST_REG_ADDR)
          begin
            i2c_d.ptr = ptr_inc;
            i2c_d.tx  = reg_rd(ptr_inc);
          end
          else
            i2c_d.tx = IDLE_BYTE;
        end
      end
      if (scl_fall)
      begin
        if (i2c_q.bitcnt == I2C_B7)
        begin
          i2c_d.bitcnt = I2C_ACK;
          case (i2c_q.state)
            I_ADDR:
            begin
              if (i2c_byte[6:0] == I2C_DEV_ADDR)
              begin
                i2c_d.drive_low = 1'b1;
                i2c_d.state     = i2c_byte[WR_BIT] ? I_REG : I_RDATA;
                i2c_d.tx        = (i2c_q.ptr <= LAST_REG_ADDR) ? reg_rd(i2c_q.ptr) : IDLE_BYTE;
              end
              else
                i2c_d.state = I_IDLE;
            end
            I_REG:
            begin
              i2c_d.ptr       = i2c_byte;
              i2c_d.drive_low = 1'b1;
              i2c_d.state     = I_WDATA;
            end
            I_WDATA:
            begin
              i2c_wr          = (i2c_q.ptr == ADDR_RATE);
              i2c_d.ptr       = ptr_inc;
              i2c_d.drive_low = 1'b1;
            end
            I_RDATA: i2c_d.drive_low = 1'b0;
            default: i2c_d.state = I_IDLE;
          endcase
        end
        else
        begin
          i2c_d.bitcnt = (i2c_q.bitcnt == I2C_ACK) ? 4'h0 : i2c_q.bitcnt + 4'h1;
          if (i2c_q.state == I_RDATA)
          begin
            i2c_d.drive_low = ~i2c_q.tx[7];
            i2c_d.tx        = {i2c_q.tx[6:0], 1'b1};
          end
          else
            i2c_d.drive_low = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      i2c_q <= I2C_RST;
    else
      i2c_q <= i2c_d;
  end

  assign i2c_sda_o    = 1'b0;
  assign i2c_sda_oe_o = i2c_q.drive_low;

  // Rate register and timestamp
  always_comb
  begin
    rate_d = rate_q;
    if (spi_wr)
      rate_d = spi_q.arg;
    else if (i2c_wr)
      rate_d = i2c_byte;
    tick_d = tick_q + 32'h1;
    ms_d   = ms_q;
    if (tick_q == 32'(TICK_CYC - 1))
    begin
      tick_d = 32'h0;
      ms_d   = ms_q + 32'h1;
    end
    ts_d = sample_ready_i ? ms_q : ts_q;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rate_q <= RATE_INIT;
      tick_q <= 32'h0;
      ms_q   <= 32'h0;
      ts_q   <= 32'h0;
    end
    else
    begin
      rate_q <= rate_d;
      tick_q <= tick_d;
      ms_q   <= ms_d;
      ts_q   <= ts_d;
    end
  end

  assign sample_rate_hz_o = rate_q;
  assign timestamp_o      = ts_q;

endmodule // sensor_register_access_port
`default_nettype wire

// >>> verification/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
#(
  parameter int Q = 32
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       spi_miso_i,
  input  wire logic       i2c_sda_i,
  output var  logic       spi_sclk_o,
  output var  logic       spi_cs_n_o,
  output var  logic       spi_mosi_o,
  output var  logic       i2c_scl_o,
  output var  logic       i2c_sda_low_o,
  output var  logic       rx_vld_o,
  output var  logic [7:0] rx_byte_o
);
  initial
  begin
    {spi_sclk_o, spi_cs_n_o, spi_mosi_o, i2c_scl_o, i2c_sda_low_o, rx_vld_o} = 6'h3C;
    rx_byte_o = 8'h00;
  end

  task automatic report(input logic [7:0] b);
    @(posedge clk_sys_i);
    rx_vld_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge clk_sys_i);
    rx_vld_o <= 1'b0;
  endtask

  task automatic spi_frame(input logic [31:0] d, input int n, input logic rep, input int gap);
    logic [7:0] r;
    @(posedge clk_sys_i);
    spi_cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (int i = n - 1; i >= 0; i--)
    begin
      for (int k = 7; k >= 0; k--)
      begin
        @(posedge clk_sys_i);
        spi_sclk_o <= 1'b0;
        spi_mosi_o <= d[8 * i + k];
        repeat (4) @(posedge clk_sys_i);
        spi_sclk_o <= 1'b1;
        r[k] = spi_miso_i;
        repeat (3) @(posedge clk_sys_i);
      end
      if (rep)
        report(r);
    end
    repeat (4) @(posedge clk_sys_i);
    spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o;
    repeat (gap) @(posedge clk_sys_i);
  endtask

  task automatic drive(input logic scl, input logic low);
    @(posedge clk_sys_i);
    i2c_scl_o <= scl;
    i2c_sda_low_o <= low;
    repeat (Q - 1) @(posedge clk_sys_i);
  endtask

  task automatic i2c_bit(input logic low, output logic s);
    drive(1'b0, low);
    drive(1'b1, low);
    s = i2c_sda_i;
    drive(1'b1, low);
    drive(1'b0, low);
  endtask

  task automatic i2c_start();
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    drive(1'b0, 1'b1);
  endtask

  task automatic i2c_stop();
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
  endtask

  // Write bytes report the acknowledge as 1, read bytes the data
  task automatic i2c_byte(input logic [7:0] b, input logic rd, input logic nack);
    logic [7:0] r;
    logic       a;
    for (int k = 7; k >= 0; k--)
      i2c_bit(!rd && !b[k], r[k]);
    i2c_bit(rd && !nack, a);
    report(rd ? r : {7'h00, !a});
  endtask
endmodule // host_bus_model
`default_nettype wire

// >>> verification/sensor_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_port_chk
(
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        spi_sclk_i,
  input wire logic        spi_cs_n_i,
  input wire logic        spi_miso_o,
  input wire logic        spi_miso_oe_o,
  input wire logic        i2c_scl_i,
  input wire logic        i2c_sda_oe_o,
  input wire logic        sample_ready_i,
  input wire logic [7:0]  sample_rate_hz_o,
  input wire logic [31:0] timestamp_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic       sclk_q, cs_q, scl_q;
  logic [7:0] bits_q, cs_age_q, scl_age_q;

  // Bits of last frame, cycles since select release and bus clock fall
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {sclk_q, cs_q, scl_q} <= 3'h7;
      bits_q <= 8'h00;
      cs_age_q <= 8'hFF;
      scl_age_q <= 8'hFF;
    end
    else
    begin
      {sclk_q, cs_q, scl_q} <= {spi_sclk_i, spi_cs_n_i, i2c_scl_i};
      bits_q <= (cs_q && !spi_cs_n_i) ? 8'h00 : bits_q + {7'h00, !spi_cs_n_i && spi_sclk_i && !sclk_q};
      cs_age_q <= (!cs_q && spi_cs_n_i) ? 8'h00 : cs_age_q + {7'h00, cs_age_q != 8'hFF};
      scl_age_q <= (scl_q && !i2c_scl_i) ? 8'h00 : scl_age_q + {7'h00, scl_age_q != 8'hFF};
    end
  end

  sequence s_sclk_high;
    (!spi_cs_n_i && spi_sclk_i) [*4];
  endsequence
  sequence s_deselected;
    spi_cs_n_i [*5];
  endsequence
  sequence s_scl_high;
    i2c_scl_i [*4];
  endsequence

  AST_RATE_CAUSE: assert property ($changed(sample_rate_hz_o) |-> cs_age_q < 8'h08 || scl_age_q < 8'h08)
    else $error("rate changed outside a finished request");
  AST_WR_BITS: assert property ($changed(sample_rate_hz_o) && cs_age_q < 8'h08 |-> bits_q >= 8'h18)
    else $error("rate changed after a short frame");
  AST_MISO_HOLD: assert property (s_sclk_high |-> $stable(spi_miso_o))
    else $error("data out moved while serial clock high");
  AST_MISO_OFF: assert property (s_deselected |-> !spi_miso_oe_o)
    else $error("data out enabled while deselected");
  AST_SDA_HOLD: assert property (s_scl_high |-> $stable(i2c_sda_oe_o))
    else $error("data line moved while bus clock high");
  AST_SDA_MIN: assert property ($rose(i2c_sda_oe_o) |-> i2c_sda_oe_o [*8])
    else $error("data line pulse too short");
  AST_TS_CAUSE: assert property ($changed(timestamp_o) |-> $past(sample_ready_i) || $past(sample_ready_i, 2))
    else $error("timestamp changed without a sample");
  AST_TS_UP: assert property ($changed(timestamp_o) |-> timestamp_o > $past(timestamp_o))
    else $error("timestamp went backwards");
endmodule // sensor_port_chk

bind sensor_register_access_port sensor_port_chk sensor_port_chk_inst
(
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .i2c_scl_i(i2c_scl_i),
  .i2c_sda_oe_o(i2c_sda_oe_o), .sample_ready_i(sample_ready_i),
  .sample_rate_hz_o(sample_rate_hz_o), .timestamp_o(timestamp_o)
);
`default_nettype wire

// >>> verification/sensor_register_access_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_register_access_port_tb
  import sensor_port_pkg::*;
;
  localparam int TICK    = 10;
  localparam int RST_CYC = 6;
  logic         clk, rst, sclk, cs_n, mosi, miso, scl, sda_low, sda_oe, ready, probe_q, rx_vld;
  logic         miso_oe, sda_o, ts_chk;
  logic [31:0]  ts, exp_ts_q[$];
  logic [7:0]   rate, rx_byte, v;
  logic [95:0]  rnd;
  sensor_info_t info;
  integer       seed = 77263;
  int           fail_count, check_count, cyc;
  logic [7:0]   exp_q[$];
  wire          sda_w = ~sda_low & (~sda_oe | sda_o);
  // Undriven data out shows the inverse
  wire          miso_w = miso_oe ? miso : ~miso;

  sensor_register_access_port #(.TICK_CYC(TICK)) sensor_register_access_port_inst
  (
    .clk_sys_i(clk), .rst_i(rst), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .i2c_scl_i(scl), .i2c_sda_i(sda_w), .i2c_sda_o(sda_o),
    .i2c_sda_oe_o(sda_oe), .info_i(info), .sample_ready_i(ready), .sample_rate_hz_o(rate), .timestamp_o(ts)
  );

  host_bus_model host_bus_model_inst
  (
    .clk_sys_i(clk), .spi_miso_i(miso_w), .i2c_sda_i(sda_w), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
    .spi_mosi_o(mosi), .i2c_scl_o(scl), .i2c_sda_low_o(sda_low), .rx_vld_o(rx_vld), .rx_byte_o(rx_byte)
  );

  always #10 clk = ~clk;

  task automatic finish_test();
    if (exp_q.size() != 0)
      fail_count++;
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic compare(input string what, input logic [7:0] seen);
    logic [7:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
    check_count++;
    if (seen !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, seen);
    end
  endtask

  task automatic compare_byte(); compare("link byte", rx_byte); endtask
  task automatic compare_rate(); compare("rate register", rate); endtask

  task automatic compare_ts();
    logic [31:0] e;
    e = exp_ts_q.size() ? exp_ts_q.pop_front() : 32'hXXXXXXXX;
    check_count++;
    if (ts !== e)
    begin
      fail_count++;
      $display("Error timestamp expected %h seen %h", e, ts);
    end
  endtask

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int k = 0; k < 8; k++)
      c = c[0] ? (c ^ CRC_POLY) >> 1 : c >> 1;
    return c;
  endfunction

  task automatic probe(input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    probe_q <= 1'b1;
    @(posedge clk);
    probe_q <= 1'b0;
  endtask

  task automatic spi_wr(input logic [7:0] a, input logic [7:0] val, input logic [7:0] flip);
    host_bus_model_inst.spi_frame({8'h00, a, val, crc_step(crc_step(8'h00, a), val) ^ flip}, 3, 1'b0, 8);
  endtask

  task automatic spi_rd(input logic [7:0] a, input logic [7:0] n, input logic [23:0] e);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(e[8 * i +: 8]);
      c = crc_step(c, e[8 * i +: 8]);
    end
    exp_q.push_back(c);
    host_bus_model_inst.spi_frame({8'h00, a, n, crc_step(crc_step(8'h00, a), n)}, 3, 1'b0, 10000);
    host_bus_model_inst.spi_frame(32'h0, n + 1, 1'b1, 8);
  endtask

  always @(posedge clk)
  begin
    ready <= ($random(seed) & 32'h7) == 32'h0;
    // Tick count (one per TICK clock cycles) at the edge that takes the sample
    if (ready && cyc >= RST_CYC)
      exp_ts_q.push_back(32'((cyc - RST_CYC) / TICK));
    ts_chk <= ready && cyc >= RST_CYC;
    if (ts_chk)
      compare_ts();
    if (rx_vld)
      compare_byte();
    if (probe_q)
      compare_rate();
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    {clk, rst, ready, probe_q, ts_chk} = 5'h08;
    rnd = {$random(seed), $random(seed), $random(seed)};
    info = rnd[87:0];
    repeat (RST_CYC) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    probe(RATE_RESET);
    v = 8'($random(seed));
    spi_wr(ADDR_RATE | 8'h80, v, 8'h00);
    probe(v);
    spi_wr(ADDR_RATE | 8'h80, ~v, 8'h01);
    probe(v);
    spi_wr(ADDR_ACC_FS | 8'h80, ~v, 8'h00);
    probe(v);
    spi_rd(ADDR_GYR_FS_L, 8'h02, {8'h00, info.rate_fs});
    spi_rd(ADDR_RATE, 8'h02, {8'h00, info.accel_fs, v});
    v = 8'($random(seed));
    repeat (3) exp_q.push_back(8'h01);
    host_bus_model_inst.i2c_start();
    host_bus_model_inst.i2c_byte({1'b1, I2C_DEV_ADDR}, 1'b0, 1'b0);
    host_bus_model_inst.i2c_byte(ADDR_RATE, 1'b0, 1'b0);
    host_bus_model_inst.i2c_byte(v, 1'b0, 1'b0);
    host_bus_model_inst.i2c_stop();
    probe(v);
    exp_q.push_back(8'h00);
    host_bus_model_inst.i2c_start();
    host_bus_model_inst.i2c_byte({1'b1, I2C_DEV_ADDR ^ 7'h01}, 1'b0, 1'b0);
    host_bus_model_inst.i2c_stop();
    repeat (3) exp_q.push_back(8'h01);
    exp_q.push_back(info.flags[7:0]);
    exp_q.push_back(info.flags[15:8]);
    exp_q.push_back(8'h00);
    host_bus_model_inst.i2c_start();
    host_bus_model_inst.i2c_byte({1'b1, I2C_DEV_ADDR}, 1'b0, 1'b0);
    host_bus_model_inst.i2c_byte(ADDR_FLAGS_L, 1'b0, 1'b0);
    host_bus_model_inst.i2c_stop();
    host_bus_model_inst.i2c_start();
    host_bus_model_inst.i2c_byte({1'b0, I2C_DEV_ADDR}, 1'b0, 1'b0);
    host_bus_model_inst.i2c_byte(8'hFF, 1'b1, 1'b0);
    host_bus_model_inst.i2c_byte(8'hFF, 1'b1, 1'b0);
    host_bus_model_inst.i2c_byte(8'hFF, 1'b1, 1'b1);
    host_bus_model_inst.i2c_stop();
    repeat (20) @(posedge clk);
    finish_test();
  end
endmodule // sensor_register_access_port_tb
`default_nettype wire
